/* File: verilog/pof_filter.sv */
// Proxy offload packet filter with its APB register file
//
// How it works
// RL1 - Each filter runs only with its enable
// RL2 - Only frames passing L2 filtering qualify
// RL3 - Bad IP or TCP/UDP checksum excludes frame
// RL4 - Exact filter matches valid receive address hits
// RL5 - ARP considered when targeted or general set
// RL6 - Targeted ARP needs valid IPv4 table target
// RL7 - General ARP: broadcast/host unicast, request opcode
// RL8 - ARP accepted with zero, one, two tags
// RL9 - ND frames with extension headers dropped silently
// RL10 - NS match forwards frame to management
// RL11 - Targeted NS needs valid IPv6 table target
// RL12 - General NS: station MAC, ICMPv6 type 0x87
// RL13 - Bad ICMPv6 checksum allowed only when unchecked
// RL14 - NS accepted with zero, one, two tags
// RL15 - MLD enable forwards matching MLD frames
// RL16 - MLD needs types 0x82, 0x83 or 0x8F
// RL17 - MLD accepted on tagged frames too
// RL18 - ARP request marked for reply code 2
// RL19 - NS marked for advertisement, 2x2 IPv6 targets
// RL20 - NS enable also offloads MLD queries
// RL21 - One register set, privileged writes only
// RL22 - Proxy only if no wake filter matched
// RL23 - Status bit set per matched filter
// RL24 - Decision taken at frame end only
// RL25 - Firmware builds reply from match bits
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module pof_filter #(
  parameter int NUM_V4 = 4,
  parameter int NUM_V6 = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_done,
  input wire pof_pkg::pof_desc_type frame_desc,
  output logic verdict_valid,
  output pof_pkg::pof_verdict_type verdict
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] ctrl;
    logic [pof_pkg::NUM_FILTERS-1:0] status;
    logic csum_ctl;
    logic [7:0] valid;
    logic [NUM_V4-1:0][31:0] ipv4;
    logic [NUM_V6-1:0][127:0] ipv6;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic vld;
    pof_pkg::pof_verdict_type verdict;
  } pof_state_type;

  pof_state_type s_reg;
  pof_state_type s_next;
  logic [NUM_V4-1:0] v4_hit;
  logic [NUM_V6-1:0] v6_hit;

  ////////////////////////////////////////////////////////////////////////
  // Address table comparators

  // IPv4 targets for targeted ARP
  generate
    for (genvar i = 0; i < NUM_V4; i++)
    begin : g_v4
      pof_addr_cmp #(.WIDTH(32)) u_cmp (
        .key(frame_desc.arp_target),
        .entry(s_reg.ipv4[i]),
        .entry_valid(s_reg.valid[i]),
        .hit(v4_hit[i])
      ); // see RL6
    end
  endgenerate

  // IPv6 targets, two offloads of two targets each
  generate
    for (genvar j = 0; j < NUM_V6; j++)
    begin : g_v6
      pof_addr_cmp #(.WIDTH(128)) u_cmp (
        .key(frame_desc.ns_target),
        .entry(s_reg.ipv6[j]),
        .entry_valid(s_reg.valid[pof_pkg::IPV6_VALID_BASE + j]),
        .hit(v6_hit[j])
      ); // see RL11 see RL19
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge write data under byte strobes
  function automatic logic [31:0] merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  // Next state

  // Register access and frame classification
  always_comb
  begin
    logic acc;
    logic mapped;
    logic [31:0] rdata;
    logic [3:0] v6_page;
    logic [1:0] v6_idx;
    int v6_lsb;
    logic [31:0] wval;
    logic tags_ok;
    logic icmp_ok;
    logic arp_req;
    logic arp_addr;
    logic v6_icmp;
    logic v6_base;
    logic is_mld;
    logic clean;
    logic ext_drop;
    logic [pof_pkg::NUM_FILTERS-1:0] m;
    logic [pof_pkg::NUM_FILTERS-1:0] clr;
    logic proxy;
    acc = psel && penable;
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    v6_page = paddr[7:4] - pof_pkg::IPV6_FIRST_PAGE;
    v6_idx = v6_page[1:0];
    v6_lsb = (3 - int'(paddr[3:2])) * 32;
    wval = 32'h0000_0000;
    clr = '0;
    m = '0;
    {tags_ok, icmp_ok, arp_req, arp_addr, v6_icmp, v6_base} = '0;
    {is_mld, clean, ext_drop, proxy} = '0;
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.vld = 1'b0;

    // Read mux and address decode
    if (paddr == pof_pkg::CTRL_OFF)
    begin
      rdata = {24'h00_0000, s_reg.ctrl};
    end
    else if (paddr == pof_pkg::STATUS_OFF)
    begin
      rdata = {26'h000_0000, s_reg.status};
    end
    else if (paddr == pof_pkg::CSUM_OFF)
    begin
      rdata = {31'h0000_0000, s_reg.csum_ctl};
    end
    else if (paddr == pof_pkg::VALID_OFF)
    begin
      rdata = {24'h00_0000, s_reg.valid};
    end
    else if (paddr[7:4] == pof_pkg::IPV4_PAGE)
    begin
      rdata = s_reg.ipv4[paddr[3:2]];
    end
    else if (paddr[7:4] >= pof_pkg::IPV6_FIRST_PAGE &&
             paddr[7:4] <= pof_pkg::IPV6_LAST_PAGE)
    begin
      rdata = s_reg.ipv6[v6_idx][v6_lsb +: 32];
    end
    else
    begin
      mapped = 1'b0;
    end

    // Access phase: answer after one wait state
    if (acc && !s_reg.pready)
    begin
      s_next.pready = 1'b1;
      s_next.pslverr = !mapped || (pwrite && !pprot[0]); // see RL21
      s_next.prdata = pwrite ? 32'h0000_0000 : rdata;
    end

    // Write takes effect at the completing edge
    if (acc && s_reg.pready && pwrite && !s_reg.pslverr)
    begin
      wval = merge(rdata, pwdata, pstrb);
      if (paddr == pof_pkg::CTRL_OFF)
      begin
        s_next.ctrl = wval[7:0]; // see RL1
      end
      else if (paddr == pof_pkg::STATUS_OFF)
      begin
        // Only strobed ones clear, unstrobed bytes never do
        clr = pwdata[pof_pkg::NUM_FILTERS-1:0] &
              {pof_pkg::NUM_FILTERS{pstrb[0]}};
      end
      else if (paddr == pof_pkg::CSUM_OFF)
      begin
        s_next.csum_ctl = wval[0];
      end
      else if (paddr == pof_pkg::VALID_OFF)
      begin
        s_next.valid = wval[7:0];
      end
      else if (paddr[7:4] == pof_pkg::IPV4_PAGE)
      begin
        s_next.ipv4[paddr[3:2]] = wval;
      end
      else
      begin
        s_next.ipv6[v6_idx][v6_lsb +: 32] = wval;
      end
    end

    // Common qualifiers of the frame
    tags_ok = frame_desc.vlan_tags <= pof_pkg::MAX_VLAN_TAGS; // see RL8
    icmp_ok = !frame_desc.icmp_csum_err ||
              !s_reg.csum_ctl; // see RL13
    arp_req = tags_ok && frame_desc.ethertype == pof_pkg::ETYPE_ARP &&
              frame_desc.arp_opcode == pof_pkg::ARP_OP_REQUEST;
    arp_addr = frame_desc.bcast || frame_desc.host_ucast; // see RL7
    v6_base = tags_ok && frame_desc.station_mac && // see RL14 see RL17
              frame_desc.ethertype == pof_pkg::ETYPE_IPV6 &&
              frame_desc.next_hdr == pof_pkg::NH_ICMPV6;
    v6_icmp = v6_base && !frame_desc.ext_hdr && icmp_ok; // see RL9
    is_mld = frame_desc.icmp_type == pof_pkg::ICMP_MLD_QUERY ||
             frame_desc.icmp_type == pof_pkg::ICMP_MLD_REPORT ||
             frame_desc.icmp_type == pof_pkg::ICMP_MLD_REPORT2; // see RL16
    clean = frame_desc.l2_pass && // see RL2
            !frame_desc.ip_csum_err && !frame_desc.l4_csum_err &&
            !frame_desc.crc_err; // see RL3

    // Per filter match, each gated by its enable; MLD queries also pass on an NS enable
    m = '0;
    m[pof_pkg::BIT_EX] = s_reg.ctrl[pof_pkg::BIT_EX] &&
                         frame_desc.exact_hit; // see RL4
    m[pof_pkg::BIT_ARP_DIR] = s_reg.ctrl[pof_pkg::BIT_ARP_DIR] &&
                              arp_req && arp_addr &&
                              (|v4_hit); // see RL5 see RL6
    m[pof_pkg::BIT_ARP] = s_reg.ctrl[pof_pkg::BIT_ARP] &&
                          arp_req && arp_addr; // see RL5 see RL7
    m[pof_pkg::BIT_NS_DIR] = s_reg.ctrl[pof_pkg::BIT_NS_DIR] && v6_icmp &&
                             frame_desc.icmp_type == pof_pkg::ICMP_NS &&
                             (|v6_hit); // see RL11
    m[pof_pkg::BIT_NS] = s_reg.ctrl[pof_pkg::BIT_NS] && v6_icmp &&
                         frame_desc.icmp_type == pof_pkg::ICMP_NS; // see RL12
    m[pof_pkg::BIT_MLD] = v6_icmp && is_mld &&
                          (s_reg.ctrl[pof_pkg::BIT_MLD] || // see RL15
                           ((s_reg.ctrl[pof_pkg::BIT_NS] ||
                             s_reg.ctrl[pof_pkg::BIT_NS_DIR]) &&
                            frame_desc.icmp_type ==
                            pof_pkg::ICMP_MLD_QUERY)); // see RL20

    // Extension header ND: discarded with no reply
    ext_drop = s_reg.ctrl[pof_pkg::BIT_PROXY_EN] && clean &&
               v6_base && frame_desc.ext_hdr &&
               (frame_desc.icmp_type == pof_pkg::ICMP_NS || is_mld) &&
               (|s_reg.ctrl[pof_pkg::BIT_MLD:pof_pkg::BIT_NS_DIR]); // see RL9
    proxy = s_reg.ctrl[pof_pkg::BIT_PROXY_EN] && clean && (|m) &&
            !frame_desc.wake_match; // see RL22 see RL10

    // Status clear by write one, frame set wins
    s_next.status = s_reg.status & ~clr;
    if (frame_done)
    begin
      s_next.vld = 1'b1; // see RL24
      s_next.verdict.to_mgmt = proxy;
      s_next.verdict.drop = !proxy && frame_desc.l2_pass &&
                            (ext_drop ||
                             (s_reg.ctrl[pof_pkg::BIT_PROXY_EN] &&
                              (|m) && !clean)); // see RL3
      s_next.verdict.to_host = !proxy && frame_desc.l2_pass &&
                               !s_next.verdict.drop;
      s_next.verdict.match = proxy ? m : '0; // see RL25
      s_next.verdict.reply_code = 8'h00;
      if (proxy && (m[pof_pkg::BIT_ARP] || m[pof_pkg::BIT_ARP_DIR]))
      begin
        s_next.verdict.reply_code = pof_pkg::ARP_OP_REPLY; // see RL18
      end
      else if (proxy && (m[pof_pkg::BIT_NS] || m[pof_pkg::BIT_NS_DIR]))
      begin
        s_next.verdict.reply_code = pof_pkg::ICMP_NA; // see RL19
      end
      if (proxy)
      begin
        s_next.status = s_next.status | m; // see RL23
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // State register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.ctrl <= pof_pkg::CTRL_RESET;
      s_reg.valid <= pof_pkg::VALID_RESET;
      s_reg.csum_ctl <= pof_pkg::CSUM_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign verdict_valid = s_reg.vld;
  assign verdict = s_reg.verdict;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_ctrl_gate_ex: // see RL1
  assert property (s_reg.vld && s_reg.verdict.match[pof_pkg::BIT_EX]
                   |-> $past(s_reg.ctrl[pof_pkg::BIT_EX]))
    else $error("exact match without its enable");

  a_l2_gate: // see RL2
  assert property (s_reg.vld && s_reg.verdict.to_mgmt
                   |-> $past(frame_desc.l2_pass))
    else $error("proxied frame failed l2 filtering");

  a_csum_excl: // see RL3
  assert property (s_reg.vld && s_reg.verdict.to_mgmt
                   |-> !$past(frame_desc.ip_csum_err) &&
                       !$past(frame_desc.l4_csum_err))
    else $error("proxied frame had bad checksum");

  a_wake_excl: // see RL22
  assert property (s_reg.vld && s_reg.verdict.to_mgmt
                   |-> !$past(frame_desc.wake_match))
    else $error("proxied frame matched a wake filter");

  a_ext_hdr_drop: // see RL9
  assert property (s_reg.vld &&
                   (|s_reg.verdict.match[pof_pkg::BIT_NS:pof_pkg::BIT_NS_DIR])
                   |-> !$past(frame_desc.ext_hdr))
    else $error("ns frame with extension header proxied");

  a_icmp_check: // see RL13
  assert property (s_reg.vld && s_reg.verdict.match[pof_pkg::BIT_NS]
                   |-> !($past(frame_desc.icmp_csum_err) &&
                         $past(s_reg.csum_ctl)))
    else $error("bad icmpv6 checksum accepted while checked");

  a_status_sticky: // see RL23
  assert property (s_reg.vld && s_reg.verdict.to_mgmt
                   |-> (s_reg.status & s_reg.verdict.match) ==
                       s_reg.verdict.match)
    else $error("status misses a matched filter");

  a_decision_time: // see RL24
  assert property (s_reg.vld |-> $past(frame_done))
    else $error("verdict without frame end");

  a_arp_reply: // see RL18
  assert property (s_reg.vld && s_reg.verdict.to_mgmt &&
                   s_reg.verdict.match[pof_pkg::BIT_ARP]
                   |-> s_reg.verdict.reply_code == pof_pkg::ARP_OP_REPLY)
    else $error("arp request not marked for reply");

  a_apb_answer: // see RL21
  assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle after wait state");

  c_arp_proxied:
  cover property (s_reg.vld && s_reg.verdict.match[pof_pkg::BIT_ARP_DIR]);

  c_ns_proxied:
  cover property (s_reg.vld && s_reg.verdict.match[pof_pkg::BIT_NS_DIR]);

  c_mld_proxied:
  cover property (s_reg.vld && s_reg.verdict.match[pof_pkg::BIT_MLD]);

  c_ext_drop:
  cover property (s_reg.vld && s_reg.verdict.drop);

endmodule : pof_filter

/* File: verilog/pof_pkg.sv */
// Constants and types of the proxy offload packet filter
package pof_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] CSUM_OFF = 8'h08;
  localparam logic [7:0] VALID_OFF = 8'h0C;
  localparam logic [3:0] IPV4_PAGE = 4'h1;
  localparam logic [3:0] IPV6_FIRST_PAGE = 4'h2;
  localparam logic [3:0] IPV6_LAST_PAGE = 4'h5;

  // Filter bit positions in control, status and match vectors
  localparam int BIT_EX = 0;
  localparam int BIT_ARP_DIR = 1;
  localparam int BIT_ARP = 2;
  localparam int BIT_NS_DIR = 3;
  localparam int BIT_NS = 4;
  localparam int BIT_MLD = 5;
  localparam int NUM_FILTERS = 6;
  localparam int BIT_PROXY_EN = 7;
  localparam int BIT_ICMP_CHECK = 0;
  localparam int IPV6_VALID_BASE = 4;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] VALID_RESET = 8'h00;
  localparam logic CSUM_RESET = 1'b0;

  // Protocol codes
  localparam logic [15:0] ETYPE_ARP = 16'h0806;
  localparam logic [15:0] ETYPE_IPV6 = 16'h86DD;
  localparam logic [15:0] ARP_OP_REQUEST = 16'h0001;
  localparam logic [7:0] ARP_OP_REPLY = 8'h02;
  localparam logic [7:0] NH_ICMPV6 = 8'h3A;
  localparam logic [7:0] ICMP_NS = 8'h87;
  localparam logic [7:0] ICMP_NA = 8'h88;
  localparam logic [7:0] ICMP_MLD_QUERY = 8'h82;
  localparam logic [7:0] ICMP_MLD_REPORT = 8'h83;
  localparam logic [7:0] ICMP_MLD_REPORT2 = 8'h8F;
  localparam logic [1:0] MAX_VLAN_TAGS = 2'h2;

  // Parsed header summary of one received frame
  typedef struct packed {
    logic l2_pass;
    logic exact_hit;
    logic bcast;
    logic host_ucast;
    logic station_mac;
    logic [1:0] vlan_tags;
    logic snap;
    logic [15:0] ethertype;
    logic [15:0] arp_opcode;
    logic [31:0] arp_target;
    logic [7:0] next_hdr;
    logic ext_hdr;
    logic [7:0] icmp_type;
    logic [127:0] ns_target;
    logic ip_csum_err;
    logic l4_csum_err;
    logic icmp_csum_err;
    logic crc_err;
    logic wake_match;
  } pof_desc_type;

  // Forwarding decision for one frame
  typedef struct packed {
    logic to_mgmt;
    logic to_host;
    logic drop;
    logic [NUM_FILTERS-1:0] match;
    logic [7:0] reply_code;
  } pof_verdict_type;

endpackage : pof_pkg

/* File: verilog/pof_addr_cmp.sv */
// One address table entry compared against a frame key
`timescale 1ns/1ps
module pof_addr_cmp #(
  parameter int WIDTH = 32
) (
  input wire logic [WIDTH-1:0] key,
  input wire logic [WIDTH-1:0] entry,
  input wire logic entry_valid,
  output logic hit
);

  // Hit only on a valid entry
  assign hit = entry_valid && (key == entry);

endmodule : pof_addr_cmp

/* File: dv/pof_mgmt_model.sv */
// Management controller model that takes forwarded frames
`timescale 1ns/1ps
module pof_mgmt_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic verdict_valid,
  input wire pof_pkg::pof_verdict_type verdict,
  output int n_fw,
  output int n_bad
);
  // Count forwarded frames, check reply code against match bits
  always @(posedge clk)
  begin
    if (reset)
    begin
      n_fw <= 0;
      n_bad <= 0;
    end
    else if (verdict_valid && verdict.to_mgmt)
    begin
      n_fw <= n_fw + 1;
      if (verdict.match == 6'h00)
        n_bad <= n_bad + 1;
      else if ((|verdict.match[2:1]) && verdict.reply_code !== 8'h02)
        n_bad <= n_bad + 1;
      else if ((|verdict.match[4:3]) && !(|verdict.match[2:1]) &&
               verdict.reply_code !== 8'h88)
        n_bad <= n_bad + 1;
    end
  end
endmodule : pof_mgmt_model

/* File: dv/proxy_offload_packet_filter_test.sv */
// Self-checking bench of the proxy offload packet filter
`timescale 1ns/1ps
module proxy_offload_packet_filter_test;
  logic clk, reset, psel, penable, pwrite, frame_done, pready, pslverr, er;
  logic [7:0] paddr, ctrl_s, valid_s;
  logic [31:0] pwdata, prdata, rd, r;
  logic [3:0] pstrb;
  logic [2:0] pprot;
  logic verdict_valid, csum_s;
  logic [5:0] st_exp;
  pof_pkg::pof_desc_type frame_desc, f;
  pof_pkg::pof_verdict_type verdict, ev;
  int n_mismatch, total_checks, seed, n_fw, n_bad, n_fw_exp, k;
  localparam logic [31:0] V4 = 32'hC0A8_0001;
  localparam logic [31:0] W6 = 32'hFE80_0A01;

  pof_filter #(.NUM_V4(4), .NUM_V6(4)) dut (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_done(frame_done),
    .frame_desc(frame_desc), .verdict_valid(verdict_valid),
    .verdict(verdict));
  pof_mgmt_model mgmt (.clk(clk), .reset(reset),
    .verdict_valid(verdict_valid), .verdict(verdict), .n_fw(n_fw),
    .n_bad(n_bad));

  // Free running clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [2:0] pr);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    pprot <= pr;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 3'h1);
    check("pslverr", 0, er);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 3'h1);
    check("prdata", e, rd);
  endtask : rdchk

  task automatic prog(input logic [7:0] c, input logic cs,
                      input logic [7:0] vb);
    ctrl_s = c;
    csum_s = cs;
    valid_s = vb;
    wr(pof_pkg::CTRL_OFF, {24'h00_0000, c});
    wr(pof_pkg::CSUM_OFF, {31'h0, cs});
    wr(pof_pkg::VALID_OFF, {24'h00_0000, vb});
    rdchk(pof_pkg::CTRL_OFF, {24'h00_0000, c});
  endtask : prog

  ////////////////////////////////////////////////////////////////////////
  // Frame that filter number kind accepts when it is enabled alone
  function automatic pof_pkg::pof_desc_type good(input int kind);
    pof_pkg::pof_desc_type g;
    g = '0;
    g.l2_pass = 1'b1;
    g.bcast = 1'b1;
    g.station_mac = 1'b1;
    g.next_hdr = 8'h3A;
    g.arp_target = V4;
    g.ns_target = {4{W6}};
    g.arp_opcode = 16'h0001;
    g.ethertype = kind < 3 ? 16'h0806 : 16'h86DD;
    g.icmp_type = kind < 5 ? 8'h87 : 8'h83;
    if (kind == 0)
    begin
      g.exact_hit = 1'b1;
      g.ethertype = 16'h0800;
    end
    return g;
  endfunction : good

  // Expected verdict from shadow register state
  function automatic pof_pkg::pof_verdict_type expect_v(
    input pof_pkg::pof_desc_type x);
    pof_pkg::pof_verdict_type v;
    logic arpk, nd, px, err, ext, tg, v6;
    logic [5:0] m;
    v = '0;
    tg = x.vlan_tags != 2'h3;
    arpk = tg && x.ethertype == 16'h0806 && x.arp_opcode == 16'h0001 &&
      (x.bcast || x.host_ucast);
    v6 = tg && x.station_mac && x.ethertype == 16'h86DD &&
      x.next_hdr == 8'h3A;
    nd = v6 && !x.ext_hdr && !(x.icmp_csum_err && csum_s);
    m[0] = ctrl_s[0] && x.exact_hit;
    m[1] = ctrl_s[1] && arpk && valid_s[0] && x.arp_target == V4;
    m[2] = ctrl_s[2] && arpk;
    m[3] = ctrl_s[3] && nd && x.icmp_type == 8'h87 && valid_s[4] &&
      x.ns_target == {4{W6}};
    m[4] = ctrl_s[4] && nd && x.icmp_type == 8'h87;
    m[5] = nd && ((ctrl_s[5] && x.icmp_type inside {8'h82, 8'h83, 8'h8F})
      || ((ctrl_s[3] || ctrl_s[4]) && x.icmp_type == 8'h82));
    err = x.ip_csum_err || x.l4_csum_err || x.crc_err;
    ext = ctrl_s[7] && !err && v6 && x.ext_hdr && (|ctrl_s[5:3]) &&
      x.icmp_type inside {8'h87, 8'h82, 8'h83, 8'h8F};
    px = ctrl_s[7] && x.l2_pass && !err && (|m) && !x.wake_match;
    v.to_mgmt = px;
    v.drop = !px && x.l2_pass && ((ctrl_s[7] && (|m) && err) || ext);
    v.to_host = x.l2_pass && !px && !v.drop;
    v.match = px ? m : 6'h00;
    v.reply_code = !px ? 8'h00 : (|m[2:1]) ? 8'h02 :
      (|m[4:3]) ? 8'h88 : 8'h00;
    return v;
  endfunction : expect_v

  // Hand one frame over and compare its verdict
  task automatic send(input pof_pkg::pof_desc_type x);
    ev = expect_v(x);
    frame_done <= 1'b1;
    frame_desc <= x;
    @(posedge clk);
    frame_done <= 1'b0;
    @(posedge clk);
    check("verdict_valid", 1, verdict_valid);
    check("verdict", ev, verdict);
    if (ev.to_mgmt)
    begin
      n_fw_exp++;
      st_exp = st_exp | ev.match;
    end
  endtask : send

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 55739;
    {psel, penable, pwrite, frame_done} = 4'h0;
    {paddr, pwdata, pstrb, pprot} = '0;
    frame_desc = '0;
    {n_mismatch, total_checks, n_fw_exp} = '0;
    st_exp = 6'h00;
    reset = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Reset values, unmapped place, unprivileged write
    rdchk(pof_pkg::CTRL_OFF, 32'h0000_0000);
    rdchk(pof_pkg::STATUS_OFF, 32'h0000_0000);
    rdchk(pof_pkg::VALID_OFF, 32'h0000_0000);
    apb(1'b0, 8'h60, 32'h0000_0000, 3'h1);
    check("unmapped err", 1, er);
    apb(1'b1, pof_pkg::CTRL_OFF, 32'h0000_00FF, 3'h0);
    check("unpriv err", 1, er);
    rdchk(pof_pkg::CTRL_OFF, 32'h0000_0000);
    wr(8'h10, V4);
    for (k = 0; k < 4; k++)
      wr(8'h20 + 8'(4 * k), W6);
    rdchk(8'h10, V4);
    // Each filter enabled alone
    for (k = 0; k < 6; k++)
    begin
      prog(8'h80 | 8'(1 << k), 1'b1, 8'h11);
      send(good(k));
      check("match", 32'(1 << k), verdict.match);
    end
    rdchk(pof_pkg::STATUS_OFF, 32'h0000_003F);
    wr(pof_pkg::STATUS_OFF, 32'h0000_003F);
    st_exp = 6'h00;
    rdchk(pof_pkg::STATUS_OFF, 32'h0000_0000);
    // Extension header and ICMPv6 checksum control
    f = good(4);
    f.ext_hdr = 1'b1;
    prog(8'h98, 1'b1, 8'h11);
    send(f);
    check("drop", 1, verdict.drop);
    f = good(4);
    f.icmp_csum_err = 1'b1;
    send(f);
    prog(8'h98, 1'b0, 8'h11);
    send(f);
    check("to_mgmt", 1, verdict.to_mgmt);
    // Tag count limit and double tagged SNAP ARP
    prog(8'h84, 1'b1, 8'h11);
    f = good(2);
    f.vlan_tags = 2'h3;
    send(f);
    check("to_host", 1, verdict.to_host);
    f.vlan_tags = 2'h2;
    f.snap = 1'b1;
    send(f);
    check("to_mgmt", 1, verdict.to_mgmt);
    // Random frames under random settings
    for (k = 0; k < 400; k++)
    begin
      r = $random(seed);
      if (k % 20 == 0)
        prog({r[9] | r[10], 1'b0, r[5:0]}, r[11],
          {3'h0, r[12], 3'h0, r[13]});
      r = $random(seed);
      f = good(int'(r[2:0]) % 6);
      f.l2_pass = r[3] | r[4];
      f.bcast = r[5];
      f.host_ucast = r[6];
      f.station_mac = r[7] | r[8];
      f.exact_hit = r[9];
      f.vlan_tags = r[11:10] == 2'h3 ? 2'h2 : r[11:10];
      f.snap = r[12];
      f.arp_opcode = r[13] ? 16'h0001 : 16'h0002;
      f.icmp_type = r[16:14] == 3'h0 ? 8'h88 : r[16] ? 8'h87 :
        r[15] ? 8'h82 : r[14] ? 8'h8F : 8'h83;
      if (r[17])
        f.arp_target = r;
      f.ns_target[0] = r[18];
      f.ip_csum_err = r[21:19] == 3'h0;
      f.l4_csum_err = r[24:22] == 3'h0;
      f.icmp_csum_err = r[25];
      f.crc_err = r[28:26] == 3'h0;
      f.wake_match = r[31:29] == 3'h0;
      f.ext_hdr = k % 9 == 4;
      send(f);
    end
    rdchk(pof_pkg::STATUS_OFF, {26'h0, st_exp});
    check("forwarded", n_fw_exp, n_fw);
    check("bad forwards", 0, n_bad);
    tally_and_finish();
  end
endmodule : proxy_offload_packet_filter_test
